// ---- pkg/axs_pkg.sv ----
// axs_pkg: types and constants for the axi slave memory front end
// assumes a single clock domain and axi3-style channels with write id
package axs_pkg;
  localparam int AXS_ADDR_W = 32;
  localparam int AXS_DATA_W = 64;
  localparam int AXS_ID_W = 4;
  localparam int AXS_LEN_W = 4;
  localparam int AXS_MEM_AW = 8;

  localparam logic [1:0] AXS_BURST_INCR = 2'b01;
  localparam logic [2:0] AXS_SIZE_MIN = 3'b000;
  localparam logic [2:0] AXS_SIZE_MAX = 3'b011;
  localparam logic [1:0] AXS_RESP_OKAY = 2'b00;
  localparam logic [2:0] AXS_WORD_LSB = 3'h3;

  // write address / read address channel content
  typedef struct packed {
    logic [AXS_ADDR_W-1:0] addr;
    logic [AXS_ID_W-1:0] id;
    logic [AXS_LEN_W-1:0] len;
    logic [2:0] size;
    logic [1:0] burst;
  } axs_addr_s;

  // write data beat content
  typedef struct packed {
    logic [AXS_DATA_W-1:0] data;
    logic [AXS_DATA_W/8-1:0] strb;
    logic last;
  } axs_wbeat_s;

  // memory port
  typedef struct packed {
    logic we;
    logic re;
    logic [AXS_MEM_AW-1:0] addr;
    logic [AXS_DATA_W-1:0] wdata;
    logic [AXS_DATA_W/8-1:0] be;
  } axs_mem_s;

  typedef enum logic [1:0] {
    AXS_W_IDLE = 2'b00,
    AXS_W_DATA = 2'b01,
    AXS_W_RESP = 2'b10
  } axs_wst_e;

  typedef enum logic [1:0] {
    AXS_R_IDLE = 2'b00,
    AXS_R_FETCH = 2'b01,
    AXS_R_DATA = 2'b10
  } axs_rst_e;
endpackage

// ---- hw/axs_ram.sv ----
// axs_ram: flip-flop memory with byte enables and one-cycle read latency
// assumes write and read never target the same cycle ordering expectations
`timescale 1ns/1ps
module axs_ram
  import axs_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // memory access
  input wire axs_mem_s mem,
  output logic [AXS_DATA_W-1:0] rdata
);
  wire logic [AXS_DATA_W-1:0] rd_word;

  genvar b;
  generate
    for (b = 0; b < AXS_DATA_W/8; b++) begin : g_lane
      // one array per byte lane keeps each lane to a single writing process
      logic [7:0] lane_r [DEPTH];
      always_ff @(posedge clk_sys) begin
        if (mem.we && mem.be[b]) begin
          lane_r[mem.addr] <= mem.wdata[b*8 +: 8];
        end
      end
      assign rd_word[b*8 +: 8] = lane_r[mem.addr];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (mem.re) begin
      rdata <= rd_word;
    end
  end
endmodule

// ---- hw/axs_front_end.sv ----
// axs_front_end: axi slave in front of an on-chip memory
// assumes the master is on clk_sys and keeps the axi valid/ready rules
//
// How it works
// - a write address is taken when valid, with awready raised as the handshake.
// - after the address each write beat is acknowledged by wready while wvalid is high.
// - write beats are accepted until the beat flagged last by the master is taken.
// - after the last beat bvalid rises with an okay code and the captured id.
// - bvalid stays high until bready is seen, then drops.
// - a write address qualifies only with valid, incrementing burst and size 0 to 3.
// - a read address is taken when valid, with arready raised as the handshake.
// - read data is fetched from memory and shown on rdata with rvalid high.
// - the next read beat is not fetched until rready takes the current one.
// - rlast is raised with the final beat of each read burst.
// - only incrementing bursts of size 0 to 3 are served, aligned or not; other requests are left unanswered.
// - the write and read state machines drive the memory write, read and address strobes.
`timescale 1ns/1ps
module axs_front_end
  import axs_pkg::*;
#(
  parameter int MEM_DEPTH = 256
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // write address channel
  input wire logic awvalid,
  input wire axs_addr_s aw,
  output logic awready,
  // write data channel
  input wire logic wvalid,
  input wire axs_wbeat_s w,
  output logic wready,
  // write response channel
  output logic bvalid,
  output logic [AXS_ID_W-1:0] bid,
  output logic [1:0] bresp,
  input wire logic bready,
  // read address channel
  input wire logic arvalid,
  input wire axs_addr_s ar,
  output logic arready,
  // read data channel
  output logic rvalid,
  output logic [AXS_DATA_W-1:0] rdata,
  output logic [AXS_ID_W-1:0] rid,
  output logic [1:0] rresp,
  output logic rlast,
  input wire logic rready
);
  axs_wst_e wst_r, wst_nxt;
  axs_rst_e rst_st_r, rst_st_nxt;
  logic [AXS_ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [AXS_ADDR_W-1:0] raddr_r, raddr_nxt;
  logic [2:0] wsize_r, wsize_nxt;
  logic [2:0] rsize_r, rsize_nxt;
  logic [AXS_LEN_W-1:0] rcnt_r, rcnt_nxt;
  logic [AXS_ID_W-1:0] wid_r, wid_nxt;
  logic [AXS_ID_W-1:0] rid_r, rid_nxt;
  logic [AXS_ADDR_W-1:0] wstep, rstep;
  logic [AXS_MEM_AW-1:0] wword, rword, mem_addr;
  axs_mem_s mem;
  logic [AXS_DATA_W-1:0] mem_rdata;

  // state decode
  wire ws_idle = (wst_r == AXS_W_IDLE);
  wire ws_data = (wst_r == AXS_W_DATA);
  wire ws_resp = (wst_r == AXS_W_RESP);
  wire rs_idle = (rst_st_r == AXS_R_IDLE);
  wire rs_fetch = (rst_st_r == AXS_R_FETCH);
  wire rs_data = (rst_st_r == AXS_R_DATA);

  // qualification of a request
  // unqualified requests never see ready; there is no error response here
  wire aw_ok = awvalid && (aw.burst == AXS_BURST_INCR) && (aw.size <= AXS_SIZE_MAX);
  wire ar_ok = arvalid && (ar.burst == AXS_BURST_INCR) && (ar.size <= AXS_SIZE_MAX);

  assign awready = ws_idle && aw_ok;
  assign arready = rs_idle && ar_ok;
  assign wready = ws_data;
  wire w_beat = wready && wvalid;
  wire b_done = bvalid && bready;
  wire r_take = rvalid && rready;
  wire r_final = (rcnt_r == '0);

  // memory strobes; writes have priority, a read waits as long as write beats are taken
  // a fetch that loses to a write beat retries in the next cycle
  wire rd_req = rs_fetch && !w_beat;
  assign wword = waddr_r[AXS_WORD_LSB +: AXS_MEM_AW];
  assign rword = raddr_r[AXS_WORD_LSB +: AXS_MEM_AW];
  assign mem_addr = w_beat ? wword : rword;
  assign mem = '{
    we: w_beat,
    re: rd_req,
    addr: mem_addr,
    wdata: w.data,
    be: w.strb
  };

  always_comb begin
    wst_nxt = wst_r;
    case (wst_r)
      AXS_W_IDLE: begin
        if (awready) begin
          wst_nxt = AXS_W_DATA;
        end
      end
      AXS_W_DATA: begin
        if (w_beat && w.last) begin
          wst_nxt = AXS_W_RESP;
        end
      end
      AXS_W_RESP: begin
        if (b_done) begin
          wst_nxt = AXS_W_IDLE;
        end
      end
      default: begin
        wst_nxt = AXS_W_IDLE;
      end
    endcase
  end

  always_comb begin
    rst_st_nxt = rst_st_r;
    case (rst_st_r)
      AXS_R_IDLE: begin
        if (arready) begin
          rst_st_nxt = AXS_R_FETCH;
        end
      end
      AXS_R_FETCH: begin
        if (rd_req) begin
          rst_st_nxt = AXS_R_DATA;
        end
      end
      AXS_R_DATA: begin
        if (r_take) begin
          rst_st_nxt = r_final ? AXS_R_IDLE : AXS_R_FETCH;
        end
      end
      default: begin
        rst_st_nxt = AXS_R_IDLE;
      end
    endcase
  end

  assign bvalid = ws_resp;
  assign bid = wid_r;
  assign bresp = AXS_RESP_OKAY;

  assign rvalid = rs_data;
  assign rdata = mem_rdata;
  assign rid = rid_r;
  assign rlast = rvalid && r_final;
  assign rresp = AXS_RESP_OKAY;

  // byte step of one beat, one to eight
  assign wstep = AXS_ADDR_W'(1) << wsize_r;
  assign rstep = AXS_ADDR_W'(1) << rsize_r;

  assign waddr_nxt = awready ? aw.addr : (w_beat ? waddr_r + wstep : waddr_r);
  assign wsize_nxt = awready ? aw.size : wsize_r;
  assign wid_nxt = awready ? aw.id : wid_r;

  // read address capture, advance and beat count
  assign raddr_nxt = arready ? ar.addr : (r_take ? raddr_r + rstep : raddr_r);
  assign rsize_nxt = arready ? ar.size : rsize_r;
  assign rcnt_nxt = arready ? ar.len : (r_take ? rcnt_r - AXS_LEN_W'(1) : rcnt_r);
  assign rid_nxt = arready ? ar.id : rid_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wst_r <= AXS_W_IDLE;
      rst_st_r <= AXS_R_IDLE;
    end else begin
      wst_r <= wst_nxt;
      rst_st_r <= rst_st_nxt;
    end
  end

  // write side registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      waddr_r <= '0;
      wsize_r <= AXS_SIZE_MIN;
      wid_r <= '0;
    end else begin
      waddr_r <= waddr_nxt;
      wsize_r <= wsize_nxt;
      wid_r <= wid_nxt;
    end
  end

  // read side registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      raddr_r <= '0;
      rsize_r <= AXS_SIZE_MIN;
      rcnt_r <= '0;
      rid_r <= '0;
    end else begin
      raddr_r <= raddr_nxt;
      rsize_r <= rsize_nxt;
      rcnt_r <= rcnt_nxt;
      rid_r <= rid_nxt;
    end
  end

  axs_ram #(
    .DEPTH(MEM_DEPTH)
  ) u_ram (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .mem(mem),
    .rdata(mem_rdata)
  );
endmodule

// ---- verification/axs_front_end_sva.sv ----
// checker: handshake rules at the front end ports
// assumes one clock, bound onto axs_front_end
`timescale 1ns/1ps
module axs_front_end_chk
  import axs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // write channels
  input wire logic awvalid,
  input wire logic awready,
  input wire axs_addr_s aw,
  input wire logic wvalid,
  input wire logic wready,
  input wire axs_wbeat_s w,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [AXS_ID_W-1:0] bid,
  input wire logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rlast,
  input wire logic rready,
  input wire logic [1:0] rresp,
  input wire logic [AXS_DATA_W-1:0] rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_aw_qual: assert property (awready |-> awvalid && aw.burst == AXS_BURST_INCR && aw.size <= AXS_SIZE_MAX)
    else $error("aw taken unqualified");
  a_w_open: assert property (awvalid && awready |=> wready) else $error("no wready");
  a_w_last: assert property (wready && !(wvalid && w.last) |=> wready) else $error("wready lost");
  a_b_rise: assert property (wvalid && wready && w.last |=> bvalid) else $error("no bvalid");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bid)) else $error("bvalid lost");
  a_r_after: assert property (arvalid && arready |-> ##[2:3] rvalid) else $error("no rvalid");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rlast})) else $error("beat moved");
  a_b_okay: assert property (bvalid |-> bresp == AXS_RESP_OKAY) else $error("bad bresp");
  a_r_okay: assert property (rvalid |-> rresp == AXS_RESP_OKAY) else $error("bad rresp");
  c_wr: cover property (bvalid && bready);
  c_rd: cover property (rvalid && rready && rlast);
  c_stall: cover property (rvalid && !rready);
endmodule
bind axs_front_end axs_front_end_chk u_chk (.*);

// ---- verification/axs_master_ack.sv ----
// far-side master: ready side of the response channels
// assumes the bench drives all request channels
`timescale 1ns/1ps
module axs_master_ack (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // response readies
  output logic bready,
  output logic rready
);
  // readies may toggle freely; random mix gives prompt and slow takes
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) {bready, rready} <= 2'h0;
    else {bready, rready} <= 2'($urandom);
endmodule

// ---- verification/axs_front_end_tb.sv ----
// bench: random bursts written, then read back
// assumes axs_master_ack supplies bready and rready
`timescale 1ns/1ps
module axs_front_end_tb;
  import axs_pkg::*;
  logic clk_sys = 0, rst_b = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  axs_addr_s aw = '0, ar = '0, c;
  axs_wbeat_s w = '0;
  logic awready, wready, bvalid, bready, arready, rvalid, rlast, rready;
  logic [AXS_ID_W-1:0] bid, rid;
  logic [1:0] bresp, rresp, s;
  logic [AXS_DATA_W-1:0] rdata, d, mem [256];
  logic [3:0] n;
  logic [7:0] idx;
  logic [31:0] a;
  logic [68:0] q [$];
  int num_errors = 0, n_checks = 0;
  axs_front_end u_axs_front_end (.*);
  axs_master_ack u_axs_master_ack (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task chk(logic [68:0] sn, ex);
    n_checks++;
    if (sn !== ex) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, sn, ex);
    end
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (rst_b && bvalid && bready) chk({bid, 1'b1, 62'h0, bresp}, q.pop_front());
    if (rst_b && rvalid && rready) chk({rid, rlast, rdata}, q.pop_front());
    if (rst_b && rvalid && rready) chk(69'(rresp), 69'(AXS_RESP_OKAY));
  end
  task burst(bit wr, logic [3:0] id);
    c = '{a, id, n, 3'(s), AXS_BURST_INCR};
    for (int i = 0; i <= n; i++) begin
      idx = 8'((a + (i << s)) >> 3);
      if (!wr) q.push_back({id, 1'(i == n), mem[idx]});
    end
    if (wr) q.push_back({id, 1'b1, 62'h0, AXS_RESP_OKAY});
    @(posedge clk_sys);
    awvalid <= wr;
    arvalid <= !wr;
    aw <= c;
    ar <= c;
    do @(negedge clk_sys); while (!(wr ? awready : arready));
    @(posedge clk_sys);
    awvalid <= 1'b0;
    arvalid <= 1'b0;
    for (int i = 0; wr && i <= n; i++) begin
      idx = 8'((a + (i << s)) >> 3);
      d = {$urandom, $urandom};
      mem[idx] = d;
      wvalid <= 1'b1;
      w <= '{d, 8'hff, 1'(i == n)};
      do @(negedge clk_sys); while (!wready);
      @(posedge clk_sys);
    end
    wvalid <= 1'b0;
    do @(negedge clk_sys); while (q.size() != 0);
  endtask
  initial begin
    void'($urandom(77500));
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      awvalid <= 1'b1;
      arvalid <= 1'b1;
      c = '{0, 1, 0, k ? 3'h4 : 3'h0, k ? AXS_BURST_INCR : 2'h0};
      aw <= c;
      ar <= c;
      repeat (4) @(negedge clk_sys) chk(69'({awready, arready}), 69'h0);
    end
    @(posedge clk_sys);
    awvalid <= 1'b0;
    arvalid <= 1'b0;
    repeat (12) begin
      s = 2'($urandom);
      n = 4'($urandom);
      a = $urandom & 32'h7f8;
      burst(1, 4'($urandom));
      burst(0, 4'($urandom));
    end
    summarize();
  end
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
endmodule
